/* File: tdpg_pkg.sv */
// Constants and types shared by the timer-driven power gating block
package tdpg_pkg;

  // Local clock and timer durations
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int T0_TIME_MS = 260;
  localparam int T1_TIME_MS = 570;
  localparam int T2_TIME_MS = 570;
  localparam int T0_CYCLES = T0_TIME_MS * CYC_PER_MS;
  localparam int T1_CYCLES = T1_TIME_MS * CYC_PER_MS;
  localparam int T2_CYCLES = T2_TIME_MS * CYC_PER_MS;
  localparam int CNT_W = 24;
  localparam int NUM_TIMERS = 3;

  // Register byte offsets
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] T0_LEN_ADDR = 12'h004;
  localparam logic [11:0] T1_LEN_ADDR = 12'h008;
  localparam logic [11:0] T2_LEN_ADDR = 12'h00C;
  localparam logic [11:0] STATUS_ADDR = 12'h010;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int CTRL_SRC_BAT = 0;

  // Status register fields
  localparam int ST_RUN0 = 0;
  localparam int ST_RUN1 = 1;
  localparam int ST_RUN2 = 2;
  localparam int ST_SW_ST1 = 3;
  localparam int ST_SW_BAT1 = 4;
  localparam int ST_SW_ST2 = 5;
  localparam int ST_SW_BAT2 = 6;
  localparam int ST_MODE = 7;
  localparam int ST_CLAMP = 8;
  localparam int ST_ARMED = 9;

  // Positions in the synchronised input vector
  localparam int IN_UPPER = 0;
  localparam int IN_LOWER = 1;
  localparam int IN_BAT_DET = 2;
  localparam int IN_BAT_UNDET = 3;
  localparam int IN_SUP_DET = 4;
  localparam int IN_SUP_UNDET = 5;
  localparam int IN_CLAMP_DET = 6;
  localparam int IN_CLAMP_REL = 7;
  localparam int IN_CAP1 = 8;
  localparam int IN_CAP2 = 9;
  localparam int IN_CMP_EN = 10;
  localparam int IN_CMP_ABOVE = 11;
  localparam int IN_REG_EN = 12;
  localparam int IN_REG_STBY = 13;
  localparam int EV_W = 8;
  localparam int IN_W = 14;

  // Input power source
  typedef enum logic {SRC_STORAGE, SRC_BATTERY} tdpg_src_e;

endpackage

/* File: tdpg_top.sv */
// Timer-driven power gating controller with APB register access
//
// Summary of operation
// - Storage source: first upper threshold starts timers 0,1; later timer 2 end restarts.
// - Battery source: first battery detect starts timers 0,1; later timer 2 end restarts.
// - Timer 2 starts when timer 1 completes and stops after its duration.
// - Storage source: lower threshold clears timers 0,1; supply undetect clears timer 2.
// - Battery source: battery undetect clears all three timers.
// - Storage to first output switch closed while timer 1 runs, open in timer 2.
// - Storage to second output closed while timer 1 runs after timer 0 ended.
// - Battery to first output switch closed while timer 1 runs, open in timer 2.
// - Battery to second output closed while timer 1 runs after timer 0 ended.
// - First output discharge enabled while both its supply switches are open.
// - Second output discharge enabled while both its supply switches are open.
// - Regulator output discharge enabled whenever the regulator is disabled.
// - External switch control high exactly while a first output switch closes.
// - External control follows battery switch on battery, else storage switch.
// - Comparator enable low routes external switch control onto shared output.
// - Comparator enable high drives shared output with comparator result.
// - Regulator off when enable low; standby select picks standby or normal.
// - Clamp turns on at detect level and off only at release level.
// - In timer mode the running flags and the source select drive the output switches.
module tdpg_top
  import tdpg_pkg::*;
#(
  parameter logic [CNT_W-1:0] FIRST_TIMER_CYCLES = CNT_W'(T0_CYCLES),
  parameter logic [CNT_W-1:0] SECOND_TIMER_CYCLES = CNT_W'(T1_CYCLES),
  parameter logic [CNT_W-1:0] THIRD_TIMER_CYCLES = CNT_W'(T2_CYCLES)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Threshold detections, asynchronous levels
  input wire logic storage_upper_det,
  input wire logic storage_lower_det,
  input wire logic battery_det,
  input wire logic battery_undet,
  input wire logic supply_det,
  input wire logic supply_undet,
  input wire logic clamp_detect_det,
  input wire logic clamp_release_det,
  // Straps and control pins, asynchronous
  input wire logic second_timer_cap_pin,
  input wire logic third_timer_cap_pin,
  input wire logic comparator_enable,
  input wire logic comparator_above,
  input wire logic regulator_enable,
  input wire logic regulator_standby_select,
  // Switch and discharge controls
  output logic storage_to_first_output_switch,
  output logic battery_to_first_output_switch,
  output logic storage_to_second_output_switch,
  output logic battery_to_second_output_switch,
  output logic first_output_discharge,
  output logic second_output_discharge,
  output logic regulator_output_discharge,
  output logic shared_control_compare_output,
  output logic regulator_on,
  output logic regulator_normal_mode,
  output logic input_overvoltage_clamp,
  // Timer flags
  output logic first_timer_running_flag,
  output logic second_timer_running_flag,
  output logic third_timer_running_flag
);

  // Last count of a timer; a zero length behaves as one cycle
  function automatic logic [CNT_W-1:0] last_count(input logic [CNT_W-1:0] len);
    last_count = (len == '0) ? '0 : len - 1'b1;
  endfunction

  logic [IN_W-1:0] pins;
  logic [IN_W-1:0] sync_a;
  logic [IN_W-1:0] sync_b;
  logic [EV_W-1:0] prev_b;
  logic [EV_W-1:0] ev;
  logic [31:0] ctrl;
  logic [CNT_W-1:0] len [NUM_TIMERS];
  logic [CNT_W-1:0] cnt [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] run;
  logic [NUM_TIMERS-1:0] done;
  logic [NUM_TIMERS-1:0] start;
  logic [NUM_TIMERS-1:0] clr;
  logic timer_mode;
  logic armed;
  logic ext_ctrl;
  tdpg_src_e src;

  assign pins = {regulator_standby_select, regulator_enable, comparator_above,
                 comparator_enable, third_timer_cap_pin, second_timer_cap_pin,
                 clamp_release_det, clamp_detect_det, supply_undet, supply_det,
                 battery_undet, battery_det, storage_lower_det,
                 storage_upper_det};

  // Two-stage synchroniser, then a third stage for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
      prev_b <= '0;
    end else begin
      sync_a <= pins;
      sync_b <= sync_a;
      prev_b <= sync_b[EV_W-1:0];
    end
  end

  // Rising edges of detections are single events
  assign ev = sync_b[EV_W-1:0] & ~prev_b;

  // APB decode
  wire setup_ph = psel && !penable;
  wire wr_en = psel && penable && pready && pwrite && !pslverr;
  wire addr_ok = (paddr == CTRL_ADDR) || (paddr == T0_LEN_ADDR) ||
                 (paddr == T1_LEN_ADDR) || (paddr == T2_LEN_ADDR) ||
                 (paddr == STATUS_ADDR);
  wire [31:0] status = {22'h000000, armed, input_overvoltage_clamp,
                        timer_mode, battery_to_second_output_switch,
                        storage_to_second_output_switch,
                        battery_to_first_output_switch,
                        storage_to_first_output_switch, run};
  wire [31:0] rd_mux = (paddr == CTRL_ADDR) ? ctrl :
                       (paddr == T0_LEN_ADDR) ? 32'(len[0]) :
                       (paddr == T1_LEN_ADDR) ? 32'(len[1]) :
                       (paddr == T2_LEN_ADDR) ? 32'(len[2]) :
                       (paddr == STATUS_ADDR) ? status : 32'h00000000;

  // Answer registered in setup phase so access completes with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !addr_ok;
      prdata <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Writable configuration; status is read only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      len[0] <= FIRST_TIMER_CYCLES;
      len[1] <= SECOND_TIMER_CYCLES;
      len[2] <= THIRD_TIMER_CYCLES;
    end else if (wr_en) begin
      if (paddr == CTRL_ADDR) ctrl <= pwdata & 32'(1 << CTRL_SRC_BAT);
      if (paddr == T0_LEN_ADDR) len[0] <= pwdata[CNT_W-1:0];
      if (paddr == T1_LEN_ADDR) len[1] <= pwdata[CNT_W-1:0];
      if (paddr == T2_LEN_ADDR) len[2] <= pwdata[CNT_W-1:0];
    end
  end

  assign src = ctrl[CTRL_SRC_BAT] ? SRC_BATTERY : SRC_STORAGE;

  // Strap sampled at supply detect; mode stays until the next detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode <= 1'b0;
    end else if (ev[IN_SUP_DET]) begin
      timer_mode <= sync_b[IN_CAP1] && sync_b[IN_CAP2];
    end
  end

  // Start and clear conditions of the chained timers
  wire first_trig = (src == SRC_BATTERY) ? ev[IN_BAT_DET] : ev[IN_UPPER];
  wire trig01 = armed ? done[2] : first_trig;
  wire clr01 = (src == SRC_BATTERY) ? ev[IN_BAT_UNDET] : ev[IN_LOWER];
  wire clr2_ev = (src == SRC_BATTERY) ? ev[IN_BAT_UNDET] :
                 ev[IN_SUP_UNDET];
  assign start = {done[1], trig01, trig01};
  assign clr = {clr2_ev || !timer_mode, {2{clr01 || !timer_mode}}};

  // Armed after the first trigger; a clear of timers 0,1 disarms, so that
  // a later threshold detection restarts the chain as a first detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (clr[0]) begin
      armed <= 1'b0;
    end else if (trig01) begin
      armed <= 1'b1;
    end
  end

  // Done pulse on the last counted cycle
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      done[i] = run[i] && (cnt[i] == last_count(len[i]));
    end
  end

  // Timers: a clear wins over a start, a start over completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= '0;
      for (int i = 0; i < NUM_TIMERS; i++) cnt[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (clr[i]) begin
          run[i] <= 1'b0;
          cnt[i] <= '0;
        end else if (start[i]) begin
          run[i] <= 1'b1;
          cnt[i] <= '0;
        end else if (done[i]) begin
          run[i] <= 1'b0;
          cnt[i] <= '0;
        end else if (run[i]) begin
          cnt[i] <= cnt[i] + 1'b1;
        end
      end
    end
  end

  // Switch decode from the running flags and the source select
  wire gate1 = run[1] && !run[2];
  wire gate2 = run[1] && !run[0] && !run[2];
  wire next_sw_st1 = (src == SRC_STORAGE) && gate1;
  wire next_sw_st2 = (src == SRC_STORAGE) && gate2;
  wire next_sw_bat1 = (src == SRC_BATTERY) && gate1;
  wire next_sw_bat2 = (src == SRC_BATTERY) && gate2;
  // Only one source is ever selected, so the OR equals the follow select
  wire next_ext = (src == SRC_BATTERY) ? next_sw_bat1 :
                  next_sw_st1;
  wire next_shared = sync_b[IN_CMP_EN] ? sync_b[IN_CMP_ABOVE] :
                     next_ext;
  wire next_clamp = ev[IN_CLAMP_DET] ? 1'b1 :
                    ev[IN_CLAMP_REL] ? 1'b0 :
                    input_overvoltage_clamp;

  // Outputs registered together so switch and discharge never overlap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      storage_to_first_output_switch <= 1'b0;
      storage_to_second_output_switch <= 1'b0;
      battery_to_first_output_switch <= 1'b0;
      battery_to_second_output_switch <= 1'b0;
      first_output_discharge <= 1'b1;
      second_output_discharge <= 1'b1;
      ext_ctrl <= 1'b0;
      shared_control_compare_output <= 1'b0;
      input_overvoltage_clamp <= 1'b0;
    end else begin
      storage_to_first_output_switch <= next_sw_st1;
      storage_to_second_output_switch <= next_sw_st2;
      battery_to_first_output_switch <= next_sw_bat1;
      battery_to_second_output_switch <= next_sw_bat2;
      first_output_discharge <= !(next_sw_st1 || next_sw_bat1);
      second_output_discharge <= !(next_sw_st2 || next_sw_bat2);
      ext_ctrl <= next_ext;
      shared_control_compare_output <= next_shared;
      input_overvoltage_clamp <= next_clamp;
    end
  end

  // Regulator mode decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_on <= 1'b0;
      regulator_normal_mode <= 1'b0;
      regulator_output_discharge <= 1'b1;
    end else begin
      regulator_on <= sync_b[IN_REG_EN];
      regulator_normal_mode <= sync_b[IN_REG_EN] && sync_b[IN_REG_STBY];
      regulator_output_discharge <= !sync_b[IN_REG_EN];
    end
  end

  assign first_timer_running_flag = run[0];
  assign second_timer_running_flag = run[1];
  assign third_timer_running_flag = run[2];

  // Checks on the gating sequence and decode
  t2_follows_t1_a: assert property (@(posedge pclk) disable iff (!presetn)
    done[1] && !clr[2] |=> run[2]) else $error("timer 2 not started");
  restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    armed && done[2] && !clr[0] |=> run[0] && run[1])
    else $error("timers 0,1 not restarted");
  first_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    !armed && first_trig && !clr[0] |=> run[1] && armed)
    else $error("first trigger missed");
  clear01_a: assert property (@(posedge pclk) disable iff (!presetn)
    clr01 |=> !run[0] && !run[1]) else $error("timers 0,1 not cleared");
  bat_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (src == SRC_BATTERY) && ev[IN_BAT_UNDET] |=> run == '0)
    else $error("battery undetect left a timer");
  t2_opens_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(run[2]) |-> !storage_to_first_output_switch &&
    !battery_to_first_output_switch) else $error("switch closed in t2");
  out2_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    storage_to_second_output_switch |-> $past(run[1] && !run[0]))
    else $error("second output closed early");
  discharge_a: assert property (@(posedge pclk) disable iff (!presetn)
    first_output_discharge != (storage_to_first_output_switch ||
    battery_to_first_output_switch)) else $error("discharge overlap");
  ext_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
    ext_ctrl == (storage_to_first_output_switch ||
    battery_to_first_output_switch)) else $error("ext control wrong");
  shared_a: assert property (@(posedge pclk) disable iff (!presetn)
    $past(!sync_b[IN_CMP_EN]) |-> shared_control_compare_output == ext_ctrl)
    else $error("shared output not routed");
  clamp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    input_overvoltage_clamp && !ev[IN_CLAMP_REL] |=> input_overvoltage_clamp)
    else $error("clamp released early");
  reg_dis_a: assert property (@(posedge pclk) disable iff (!presetn)
    regulator_output_discharge == !regulator_on)
    else $error("regulator discharge wrong");

endmodule

/* File: tdpg_load_model.sv */
// Load model on the gated outputs: fits both timer caps, tracks rail power
module tdpg_load_model (
  // Clock
  input wire logic pclk,
  // Supply switches from the controller
  input wire logic sw_st1,
  input wire logic sw_bat1,
  input wire logic sw_st2,
  input wire logic sw_bat2,
  // Timer capacitor straps
  output logic cap1_fitted,
  output logic cap2_fitted,
  // Load rail state
  output logic out1_powered,
  output logic out2_powered
);
  // Both caps fitted, so the controller must pick timer-driven gating
  assign cap1_fitted = 1'b1;
  assign cap2_fitted = 1'b1;
  // Rails lag the switches by a clock, as a loaded rail would
  always_ff @(posedge pclk) begin
    out1_powered <= sw_st1 | sw_bat1;
    out2_powered <= sw_st2 | sw_bat2;
  end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the timer-driven power gating controller
module tb_top
  import tdpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int L0 = 8;
  localparam int L1 = 20;
  localparam int L2 = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, err, cap1, cap2, pwr1, pwr2;
  logic [7:0] det = 8'h00;
  logic cmp_en = 1'b0;
  logic cmp_above = 1'b0;
  logic reg_en = 1'b0;
  logic reg_stby = 1'b0;
  logic st1, bat1, st2, bat2, dis1, dis2, dis_reg, shared;
  logic reg_on, reg_norm, clamp, run0, run1, run2;
  logic [2:0] e;
  int n_fail = 0;
  int checks_done = 0;
  int seed = 19090;
  int cycles = 0;
  wire [2:0] run = {run2, run1, run0};
  wire [6:0] outs = {shared, dis2, dis1, bat2, st2, bat1, st1};
  wire [2:0] ldo = {reg_on, reg_norm, dis_reg};

  // Short timer lengths keep the run brief
  tdpg_top #(.FIRST_TIMER_CYCLES(CNT_W'(L0)),
    .SECOND_TIMER_CYCLES(CNT_W'(L1)), .THIRD_TIMER_CYCLES(CNT_W'(L2))
  ) i_tdpg_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr,
    .storage_upper_det(det[IN_UPPER]), .storage_lower_det(det[IN_LOWER]),
    .battery_det(det[IN_BAT_DET]), .battery_undet(det[IN_BAT_UNDET]),
    .supply_det(det[IN_SUP_DET]), .supply_undet(det[IN_SUP_UNDET]),
    .clamp_detect_det(det[IN_CLAMP_DET]),
    .clamp_release_det(det[IN_CLAMP_REL]),
    .second_timer_cap_pin(cap1), .third_timer_cap_pin(cap2),
    .comparator_enable(cmp_en), .comparator_above(cmp_above),
    .regulator_enable(reg_en), .regulator_standby_select(reg_stby),
    .storage_to_first_output_switch(st1),
    .battery_to_first_output_switch(bat1),
    .storage_to_second_output_switch(st2),
    .battery_to_second_output_switch(bat2),
    .first_output_discharge(dis1), .second_output_discharge(dis2),
    .regulator_output_discharge(dis_reg),
    .shared_control_compare_output(shared), .regulator_on(reg_on),
    .regulator_normal_mode(reg_norm), .input_overvoltage_clamp(clamp),
    .first_timer_running_flag(run0), .second_timer_running_flag(run1),
    .third_timer_running_flag(run2));

  tdpg_load_model i_tdpg_load_model (.pclk, .sw_st1(st1), .sw_bat1(bat1),
    .sw_st2(st2), .sw_bat2(bat2), .cap1_fitted(cap1),
    .cap2_fitted(cap2), .out1_powered(pwr1), .out2_powered(pwr2));

  // Clock and hang guard; a full run needs well under 3000 cycles
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count assumed; only the bench hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Detection pulse long enough to pass the synchronisers
  task automatic pin(input int i);
    @(posedge pclk);
    det[i] <= 1'b1;
    repeat (6) @(posedge pclk);
    det[i] <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // Expected {shared, dis2, dis1, bat2, st2, bat1, st1}; phase = timer
  function automatic logic [6:0] exp_out(input int ph, input logic bat);
    logic [1:0] fo;
    logic [1:0] so;
    fo = (ph < 2) ? (bat ? 2'b10 : 2'b01) : 2'b00;
    so = (ph == 1) ? fo : 2'b00;
    return {|fo, ~|so, ~|fo, so, fo};
  endfunction

  // Waits for a timer to run, counts its length, checks outputs inside
  task automatic measure(input int i, input int len, input logic bat);
    int n;
    n = 0;
    while (run[i] !== 1'b1 && n < 500) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    while (run[i] === 1'b1) begin
      @(negedge pclk);
      n++;
      if (n == 3) chk("outs", 32'(outs), 32'(exp_out(i, bat)));
    end
    chk("timer length", n, len);
  endtask

  // Gating round: first start, chain, restart, then a clearing event
  task automatic gate(input logic bat, input int start, input int clr);
    apb(1'b1, CTRL_ADDR, {31'h0, bat});
    det[start] <= 1'b1;
    measure(0, L0, bat);
    repeat (3) @(negedge pclk);
    chk("both on", 32'(outs), 32'(exp_out(1, bat)));
    chk("rails", 32'({pwr2, pwr1}), 32'h3);
    measure(2, L2, bat);
    measure(0, L0, bat);
    @(posedge pclk);
    det[clr] <= 1'b1;
    repeat (6) @(negedge pclk);
    chk("cleared", 32'(run), 32'h0);
    @(posedge pclk);
    det <= 8'h00;
    repeat (5) @(posedge pclk);
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk("ctrl reset", rd, CTRL_RST);
    apb(1'b0, T2_LEN_ADDR, 32'h0);
    chk("len reset", rd, 32'(L2));
    apb(1'b1, 12'h040, 32'hFFFFFFFF);
    chk("unmapped", 32'(err), 32'h1);
    chk("idle outs", 32'(outs), 32'(exp_out(2, 1'b0)));
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      apb(1'b1, T1_LEN_ADDR, v);
      apb(1'b0, T1_LEN_ADDR, 32'h0);
      chk("len readback", rd, v & 32'h00FFFFFF);
    end
    apb(1'b1, T1_LEN_ADDR, 32'(L1));
    pin(IN_UPPER);
    chk("no mode", 32'(run), 32'h0);
    pin(IN_SUP_DET);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("timer mode", 32'(rd[ST_MODE]), 32'h1);
    gate(1'b0, IN_UPPER, IN_LOWER);
    gate(1'b1, IN_BAT_DET, IN_BAT_UNDET);
    for (int k = 0; k < 8; k++) begin
      v = $random(seed);
      @(posedge pclk);
      cmp_en <= v[0];
      cmp_above <= v[1];
      repeat (6) @(posedge pclk);
      chk("shared", 32'(shared), 32'(v[0] & v[1]));
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      reg_en <= k[1];
      reg_stby <= k[0];
      e = {k[1], &k[1:0], ~k[1]};
      repeat (6) @(posedge pclk);
      chk("regulator", 32'(ldo), 32'(e));
    end
    pin(IN_CLAMP_DET);
    chk("clamp held", 32'(clamp), 32'h1);
    pin(IN_CLAMP_REL);
    chk("clamp off", 32'(clamp), 32'h0);
    test_done();
  end
endmodule
